// ### core/rtc_core.sv
// rtc_core: status flags, interrupt pins and calendar counters
// assumes a register port in the core clock domain and a free crystal clock
//
// What this block does
// - halt flag sets when oscillation stops and stays set afterwards
// - while halted, config bits other than hour format clear and first interrupt pin idles
// - while halted, second interrupt pin carries the crystal clock
// - writing control 2 with the oscillator running clears halt flag
// - clock output disable 0 gives crystal clock pulses, 1 stops them
// - periodic flag reads 1 exactly while the periodic output is low
// - level mode: writing 0 clears periodic flag, writing 1 does nothing
// - alarm flag sets when current time matches that alarm
// - alarm flag cleared by writing 0 or by disabling that alarm, releasing its pin
// - alarm raises interrupt only when its enable is 1
// - disabled alarm is inactive and its flag reads 0
// - seconds count bcd 00..59, wrap carries into minutes
// - minutes count bcd 00..59, wrap carries into hours
// - hour rollover past 11 pm or 23 carries to day and weekday
// - weekday counts 0 to 6 then wraps to 0 on each day carry
// - month counts 1 to 12, return to 1 carries to year
// - years divisible by four are leap, february has 29 days
// - hour format 0 is 12-hour with pm bit 5, 1 is 24-hour
`default_nettype none

module rtc_core
  import rtc_pkg::*;
#(
  parameter int SEC_DIV = SEC_DIV_DFLT
) (
  input  wire logic            core_clk_i,
  input  wire logic            rst_i,
  input  wire logic            xtal_clk_i,
  input  wire rtc_reg_req_type reg_req_i,
  input  wire logic [1:0]      alarm_match_i,
  input  wire logic [7:0]      year_count_i,
  output logic [7:0]           reg_rdata_o,
  output logic                 year_carry_o,
  output logic                 irq_out_first_o,
  output logic                 irq_out_first_oe_o,
  output logic                 irq_out_second_o,
  output logic                 irq_out_second_oe_o
);

  localparam logic [11:0] WD_MAX = 12'(OSC_TIMEOUT_CYC);

  localparam rtc_core_state_type STATE_RST = '{
    hour:            HOUR_RST,
    day:             DAY_RST,
    mon:             DAY_RST,
    wday:            WDAY_RST,
    halt:            1'b1,
    periodic_select: PER_OFF,
    default:         '0
  };

  if (SEC_DIV % 4 != 0 || SEC_DIV < 8 || SEC_DIV > 262144) begin : g_chk
    $error("rtc_core: SEC_DIV must be a multiple of 4 in 8..262144");
  end
  if (OSC_TIMEOUT_CYC >= 4096) begin : g_chk_wd
    $error("rtc_core: oscillator timeout too long for its counter");
  end

  rtc_core_state_type s;
  rtc_core_state_type n;

  logic qtr_toggle;
  logic wr_c2;
  logic adj;
  logic osc_edge;
  logic osc_ok;
  logic qtr_edge;
  logic sec_tick;
  logic sec_wrap;
  logic min_wrap;
  logic day_carry;
  logic day_wrap;
  logic mon_wrap;
  logic per_event;
  logic clk_en;

  rtc_prescaler #(
    .QTR_DIV (SEC_DIV / 4)
  ) u_presc (
    .xtal_clk_i   (xtal_clk_i),
    .rst_i        (rst_i),
    .qtr_toggle_o (qtr_toggle)
  );

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v + 8'h01;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end
    return r;
  endfunction

  // 12-hour: 12 am, 01..11, then 32 (noon), 21..31, then 12 am
  function automatic logic [7:0] hour_next(input logic [7:0] h,
                                           input logic       h24);
    logic [7:0] r;
    r = bcd_inc(h);
    if (h24) begin
      if (h == H24_LAST) begin
        r = SEC_RST;
      end
    end else if (h[4:0] == H12_TOP) begin
      r = {h[7:5], H12_ONE};
    end else if (h[4:0] == H12_BEFORE) begin
      r = {h[7:6], ~h[5], H12_TOP};
    end
    return r;
  endfunction

  function automatic logic [7:0] last_day(input logic [7:0] m,
                                          input logic [7:0] y);
    logic leap;
    logic [7:0] r;
    // bcd year: odd tens need ones 2 or 6, even tens 0, 4 or 8
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    r = DAYS_LONG;
    if (m == MON_FEB) begin
      r = leap ? DAYS_LEAP : DAYS_FEB;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      r = DAYS_SHORT;
    end
    return r;
  endfunction

  always_comb begin
    n     = s;
    wr_c2 = reg_req_i.wr && reg_req_i.addr == ADDR_CTRL2;
    adj   = wr_c2 && reg_req_i.wdata[C2_ADJ];

    // crystal watchdog: no edge for the timeout means it stopped
    n.xtal_sync = {s.xtal_sync[0], xtal_clk_i};
    n.xtal_prev = s.xtal_sync[1];
    osc_edge    = s.xtal_sync[1] ^ s.xtal_prev;
    osc_ok      = s.wd_cnt != WD_MAX;
    if (osc_edge) begin
      n.wd_cnt = '0;
    end else if (osc_ok) begin
      n.wd_cnt = s.wd_cnt + 12'h001;
    end

    n.qtr_sync = {s.qtr_sync[0], qtr_toggle};
    n.qtr_prev = s.qtr_sync[1];
    qtr_edge   = s.qtr_sync[1] ^ s.qtr_prev;
    if (qtr_edge) begin
      n.qtr = s.qtr + 2'h1;
    end
    sec_tick = qtr_edge && s.qtr == 2'h3;

    // carry chain; adjust rounds to the nearest minute
    sec_wrap  = (sec_tick && s.sec == SEC_MAX)
             || (adj && s.sec >= ADJ_ROUND);
    min_wrap  = sec_wrap && s.min == SEC_MAX;
    day_carry = min_wrap
             && s.hour == (s.hour24 ? H24_LAST : H12_LAST);
    day_wrap  = day_carry && s.day == last_day(s.mon, year_count_i);
    mon_wrap  = day_wrap && s.mon == MON_MAX;

    if (adj) begin
      n.sec = SEC_RST;
    end else if (sec_tick) begin
      n.sec = sec_wrap ? SEC_RST : bcd_inc(s.sec);
    end
    if (sec_wrap) begin
      n.min = min_wrap ? SEC_RST : bcd_inc(s.min);
    end
    if (min_wrap) begin
      n.hour = hour_next(s.hour, s.hour24);
    end
    if (day_carry) begin
      n.wday = (s.wday == WDAY_LAST) ? WDAY_RST : s.wday + 3'h1;
      n.day  = day_wrap ? DAY_RST : bcd_inc(s.day);
    end
    if (day_wrap) begin
      n.mon = mon_wrap ? DAY_RST : bcd_inc(s.mon);
    end
    n.year_carry = mon_wrap;

    unique case (s.periodic_select)
      PER_OFF:       per_event = 1'b0;
      PER_FIXED_LOW: per_event = 1'b0;
      PER_PULSE_2HZ: per_event = 1'b0;
      PER_PULSE_1HZ: per_event = 1'b0;
      PER_LVL_SEC:   per_event = sec_tick;
      PER_LVL_MIN:   per_event = sec_wrap;
      PER_LVL_HOUR:  per_event = min_wrap;
      PER_LVL_MONTH: per_event = day_wrap;
    endcase

    // pulse modes follow the quarter phase; level modes latch
    unique case (s.periodic_select)
      PER_OFF:       n.periodic_irq_flag = 1'b0;
      PER_FIXED_LOW: n.periodic_irq_flag = 1'b1;
      PER_PULSE_2HZ: n.periodic_irq_flag = ~n.qtr[0];
      PER_PULSE_1HZ: n.periodic_irq_flag = ~n.qtr[1];
      PER_LVL_SEC, PER_LVL_MIN, PER_LVL_HOUR, PER_LVL_MONTH: begin
        if (wr_c2 && !reg_req_i.wdata[C2_PERIODIC_IRQ_FLAG]) begin
          n.periodic_irq_flag = 1'b0;
        end
        if (per_event) begin
          n.periodic_irq_flag = 1'b1;
        end
      end
    endcase

    // a match in the clearing cycle wins over the clear
    for (int i = 0; i < 2; i++) begin
      if (wr_c2 && !reg_req_i.wdata[C2_AFLAG0 - i]) begin
        n.alarm_match_flag[i] = 1'b0;
      end
      if (alarm_match_i[i] && s.alarm_enable[i]) begin
        n.alarm_match_flag[i] = 1'b1;
      end
    end

    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        ADDR_SEC:  n.sec  = reg_req_i.wdata & SEC_MASK;
        ADDR_MIN:  n.min  = reg_req_i.wdata & SEC_MASK;
        ADDR_HOUR: n.hour = reg_req_i.wdata & HOUR_MASK;
        ADDR_WDAY: n.wday = reg_req_i.wdata[2:0];
        ADDR_DAY:  n.day  = reg_req_i.wdata & HOUR_MASK;
        ADDR_MON:  n.mon  = reg_req_i.wdata & MON_MASK;
        ADDR_TRIM: begin
          n.crystal_select = reg_req_i.wdata[7];
          n.trim_value     = reg_req_i.wdata[6:0];
        end
        ADDR_CTRL1: begin
          n.alarm_enable     = reg_req_i.wdata[7:6];
          n.irq_route_select = reg_req_i.wdata[5:4];
          n.test_mode        = reg_req_i.wdata[3];
          n.periodic_select  = rtc_periodic_type'(reg_req_i.wdata[2:0]);
        end
        ADDR_CTRL2: begin
          n.hour24            = reg_req_i.wdata[C2_HOUR24];
          n.clk_out_disable_n = reg_req_i.wdata[C2_CLKDIS];
        end
        default: ;
      endcase
    end

    if (!osc_ok) begin
      n.halt = 1'b1;
    end else if (wr_c2) begin
      n.halt = 1'b0;
    end
    if (n.halt) begin
      n.crystal_select    = 1'b0;
      n.trim_value        = '0;
      n.periodic_select   = PER_OFF;
      n.alarm_enable      = '0;
      n.irq_route_select  = '0;
      n.clk_out_disable_n = 1'b0;
      n.test_mode         = 1'b0;
    end
    for (int i = 0; i < 2; i++) begin
      if (!n.alarm_enable[i]) begin
        n.alarm_match_flag[i] = 1'b0;
      end
    end

    // routing: bit 0 moves alarm 1, bit 1 moves periodic to pin two
    clk_en     = n.halt || !n.clk_out_disable_n;
    n.first_oe = !n.halt
              && (n.alarm_match_flag[0]
              || (n.alarm_match_flag[1] && !n.irq_route_select[0])
              || (n.periodic_irq_flag && !n.irq_route_select[1]));
    n.second_oe = (clk_en && !s.xtal_sync[1])
               || (n.alarm_match_flag[1] && n.irq_route_select[0])
               || (n.periodic_irq_flag && n.irq_route_select[1]);
    n.pin_low = 1'b0;

    case (reg_req_i.addr)
      ADDR_SEC:   n.rdata = s.sec;
      ADDR_MIN:   n.rdata = s.min;
      ADDR_HOUR:  n.rdata = s.hour;
      ADDR_WDAY:  n.rdata = {5'h00, s.wday};
      ADDR_DAY:   n.rdata = s.day;
      ADDR_MON:   n.rdata = s.mon;
      ADDR_TRIM:  n.rdata = {s.crystal_select, s.trim_value};
      ADDR_CTRL1: n.rdata = {s.alarm_enable, s.irq_route_select,
                             s.test_mode, s.periodic_select};
      ADDR_CTRL2: n.rdata = {2'h0, s.hour24, s.halt,
                             s.clk_out_disable_n, s.periodic_irq_flag,
                             s.alarm_match_flag[0], s.alarm_match_flag[1]};
      default:    n.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata_o         = s.rdata;
  assign year_carry_o        = s.year_carry;
  assign irq_out_first_o     = s.pin_low;
  assign irq_out_first_oe_o  = s.first_oe;
  assign irq_out_second_o    = s.pin_low;
  assign irq_out_second_oe_o = s.second_oe;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_halt_sticky;
    s.halt && !wr_c2 |=> s.halt;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky)
    else $error("halt flag dropped without a control write");

  property p_halt_quiet;
    s.halt |-> !irq_out_first_oe_o && s.alarm_enable == 2'h0
      && s.periodic_select == PER_OFF && !s.clk_out_disable_n;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet)
    else $error("halted but config or first pin active");

  property p_halt_clock;
    s.halt && !wr_c2 && !s.xtal_sync[1] |=> irq_out_second_oe_o;
  endproperty
  a_halt_clock: assert property (p_halt_clock)
    else $error("halted but crystal clock missing on second pin");

  property p_halt_clear;
    wr_c2 && osc_ok |=> !s.halt;
  endproperty
  a_halt_clear: assert property (p_halt_clear)
    else $error("control write did not clear halt flag");

  property p_clk_disable;
    s.clk_out_disable_n && s.irq_route_select == 2'h0
      |-> !irq_out_second_oe_o;
  endproperty
  a_clk_disable: assert property (p_clk_disable)
    else $error("clock output not disabled");

  property p_periodic_irq_flag_pin;
    s.periodic_irq_flag && !s.halt |-> irq_out_first_oe_o || irq_out_second_oe_o;
  endproperty
  a_periodic_irq_flag_pin: assert property (p_periodic_irq_flag_pin)
    else $error("periodic flag set but no pin low");

  property p_periodic_irq_flag_clear;
    wr_c2 && !reg_req_i.wdata[C2_PERIODIC_IRQ_FLAG] && !per_event
      && s.periodic_select >= PER_LVL_SEC |=> !s.periodic_irq_flag;
  endproperty
  a_periodic_irq_flag_clear: assert property (p_periodic_irq_flag_clear)
    else $error("periodic flag not cleared by write of 0");

  property p_alarm_set;
    alarm_match_i[0] && s.alarm_enable[0] && osc_ok && !reg_req_i.wr
      |=> s.alarm_match_flag[0] ##1 irq_out_first_oe_o || reg_req_i.wr;
  endproperty
  a_alarm_set: assert property (p_alarm_set)
    else $error("alarm match did not set flag and pin");

  property p_alarm_off;
    !s.alarm_enable[1] |-> !s.alarm_match_flag[1];
  endproperty
  a_alarm_off: assert property (p_alarm_off)
    else $error("disabled alarm flag reads 1");

  property p_sec_wrap;
    sec_tick && s.sec == SEC_MAX && !reg_req_i.wr
      |=> s.sec == SEC_RST && s.min != $past(s.min);
  endproperty
  a_sec_wrap: assert property (p_sec_wrap)
    else $error("seconds wrap did not carry");

  property p_wday_wrap;
    day_carry && s.wday == WDAY_LAST && !reg_req_i.wr
      |=> s.wday == WDAY_RST;
  endproperty
  a_wday_wrap: assert property (p_wday_wrap)
    else $error("weekday did not wrap to 0");

endmodule

`default_nettype wire

// ### core/rtc_pkg.sv
// rtc_pkg: register map, field positions, reset values and carrier types
// assumes a 20 MHz core clock and a free 32 kHz crystal clock
`default_nettype none

package rtc_pkg;

  // internal register addresses
  localparam logic [3:0] ADDR_SEC   = 4'h0;
  localparam logic [3:0] ADDR_MIN   = 4'h1;
  localparam logic [3:0] ADDR_HOUR  = 4'h2;
  localparam logic [3:0] ADDR_WDAY  = 4'h3;
  localparam logic [3:0] ADDR_DAY   = 4'h4;
  localparam logic [3:0] ADDR_MON   = 4'h5;
  localparam logic [3:0] ADDR_TRIM  = 4'h7;
  localparam logic [3:0] ADDR_CTRL1 = 4'hE;
  localparam logic [3:0] ADDR_CTRL2 = 4'hF;

  // control 2 bit positions (bit 4 is adjust on write, halt on read)
  localparam int C2_HOUR24 = 5;
  localparam int C2_ADJ    = 4;
  localparam int C2_CLKDIS = 3;
  localparam int C2_PERIODIC_IRQ_FLAG   = 2;
  localparam int C2_AFLAG0 = 1;
  localparam int C2_AFLAG1 = 0;

  // value masks of the counter registers
  localparam logic [7:0] SEC_MASK  = 8'h7F;
  localparam logic [7:0] HOUR_MASK = 8'h3F;
  localparam logic [7:0] MON_MASK  = 8'h1F;

  // bcd limits
  localparam logic [7:0] SEC_MAX    = 8'h59;
  localparam logic [7:0] ADJ_ROUND  = 8'h30;
  localparam logic [7:0] H24_LAST   = 8'h23;
  localparam logic [7:0] H12_LAST   = 8'h31;
  localparam logic [4:0] H12_TOP    = 5'h12;
  localparam logic [4:0] H12_BEFORE = 5'h11;
  localparam logic [4:0] H12_ONE    = 5'h01;
  localparam logic [7:0] MON_MAX    = 8'h12;
  localparam logic [7:0] MON_FEB    = 8'h02;
  localparam logic [7:0] DAYS_LONG  = 8'h31;
  localparam logic [7:0] DAYS_SHORT = 8'h30;
  localparam logic [7:0] DAYS_LEAP  = 8'h29;
  localparam logic [7:0] DAYS_FEB   = 8'h28;

  // reset values and last weekday
  localparam logic [7:0] SEC_RST   = 8'h00;
  localparam logic [7:0] HOUR_RST  = 8'h12;
  localparam logic [7:0] DAY_RST   = 8'h01;
  localparam logic [2:0] WDAY_RST  = 3'h0;
  localparam logic [2:0] WDAY_LAST = 3'h6;

  // timing
  localparam int CORE_CLK_HZ     = 20_000_000;
  localparam int OSC_TIMEOUT_NS  = 100_000;
  localparam int OSC_TIMEOUT_CYC =
    OSC_TIMEOUT_NS / (1_000_000_000 / CORE_CLK_HZ);
  localparam int SEC_DIV_DFLT    = 32_768;

  typedef enum logic [2:0] {
    PER_OFF, PER_FIXED_LOW, PER_PULSE_2HZ, PER_PULSE_1HZ,
    PER_LVL_SEC, PER_LVL_MIN, PER_LVL_HOUR, PER_LVL_MONTH
  } rtc_periodic_type;

  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rtc_reg_req_type;

  typedef struct packed {
    logic [15:0] cnt;
    logic        qtr_toggle;
  } rtc_presc_state_type;

  typedef struct packed {
    logic [7:0]       sec;
    logic [7:0]       min;
    logic [7:0]       hour;
    logic [2:0]       wday;
    logic [7:0]       day;
    logic [7:0]       mon;
    logic             hour24;
    logic             halt;
    logic             clk_out_disable_n;
    logic             periodic_irq_flag;
    logic [1:0]       alarm_match_flag;
    logic [1:0]       alarm_enable;
    logic [1:0]       irq_route_select;
    logic             test_mode;
    rtc_periodic_type periodic_select;
    logic             crystal_select;
    logic [6:0]       trim_value;
    logic [1:0]       xtal_sync;
    logic             xtal_prev;
    logic [11:0]      wd_cnt;
    logic [1:0]       qtr_sync;
    logic             qtr_prev;
    logic [1:0]       qtr;
    logic [7:0]       rdata;
    logic             first_oe;
    logic             second_oe;
    logic             pin_low;
    logic             year_carry;
  } rtc_core_state_type;

endpackage

`default_nettype wire

// ### core/rtc_prescaler.sv
// rtc_prescaler: quarter-second toggle on the crystal clock
// assumes rst_i is released while the crystal is stopped or slow
`default_nettype none

module rtc_prescaler
  import rtc_pkg::*;
#(
  parameter int QTR_DIV = SEC_DIV_DFLT / 4
) (
  input  wire logic xtal_clk_i,
  input  wire logic rst_i,
  output logic      qtr_toggle_o
);

  localparam logic [15:0] CNT_LAST = 16'(QTR_DIV - 1);

  rtc_presc_state_type s;
  rtc_presc_state_type n;

  if (QTR_DIV < 2 || QTR_DIV > 65536) begin : g_chk
    $error("rtc_prescaler: QTR_DIV out of range");
  end

  // a toggle, not a pulse, so the slow domain event survives the crossing
  always_comb begin
    n = s;
    if (s.cnt == CNT_LAST) begin
      n.cnt        = '0;
      n.qtr_toggle = ~s.qtr_toggle;
    end else begin
      n.cnt = s.cnt + 16'h0001;
    end
  end

  always_ff @(posedge xtal_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign qtr_toggle_o = s.qtr_toggle;

endmodule

`default_nettype wire

// ### tb/rtc_host_model.sv
// rtc_host_model: register-port master standing in for the serial host
// assumes the core takes requests on the rising core clock edge
`default_nettype none

module rtc_host_model
  import rtc_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic [7:0]       rdata_i,
  output var rtc_reg_req_type   req_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial req_o = '0;

  // one write per call; data lines scrambled once released
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    req_o.wr    = 1'b1;
    req_o.addr  = a;
    req_o.wdata = (a == ADDR_WDAY && d[2:0] == 3'h7) ? 8'h00 : d;
    @(posedge core_clk_i);
    #1;
    req_o.wr    = 1'b0;
    req_o.wdata = ~d;
  endtask

  // read data is registered, so it lands one edge after the address
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    #1;
    req_o.wr   = 1'b0;
    req_o.addr = a;
    @(posedge core_clk_i);
    #1;
    d = rdata_i;
  endtask
endmodule

`default_nettype wire

// ### tb/tb_rtc_status_and_calendar_counters.sv
// tb_rtc_status_and_calendar_counters: self-checking bench of rtc_core
// assumes rtc_host_model drives the register port, crystal made here
`default_nettype none

module tb_rtc_status_and_calendar_counters
  import rtc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;

  logic            core_clk    = 1'b0;
  logic            rst         = 1'b1;
  logic            xtal        = 1'b0;
  logic            xtal_run    = 1'b1;
  logic [1:0]      amatch      = 2'h0;
  logic [7:0]      year        = 8'h00;
  logic            ycarry_seen = 1'b0;
  int              n_mismatch  = 0;
  int              check_count = 0;
  int              cyc         = 0;
  rtc_reg_req_type req;
  logic [7:0]      rdata;
  logic            ycarry;
  logic            f_oe;
  logic            s_oe;
  logic            f_dat;
  logic            s_dat;

  always #25 core_clk = ~core_clk;

  // crystal stops only while the halt sensing is being provoked
  always begin
    #24;
    if (xtal_run) xtal = ~xtal;
  end

  rtc_host_model host_u (
    .core_clk_i (core_clk),
    .rdata_i    (rdata),
    .req_o      (req)
  );

  rtc_core #(.SEC_DIV(16)) dut_u (
    .core_clk_i          (core_clk),
    .rst_i               (rst),
    .xtal_clk_i          (xtal),
    .reg_req_i           (req),
    .alarm_match_i       (amatch),
    .year_count_i        (year),
    .reg_rdata_o         (rdata),
    .year_carry_o        (ycarry),
    .irq_out_first_o     (f_dat),
    .irq_out_first_oe_o  (f_oe),
    .irq_out_second_o    (s_dat),
    .irq_out_second_oe_o (s_oe)
  );

  task automatic tally_and_finish();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (ycarry === 1'b1) ycarry_seen <= 1'b1;
    if (cyc == 12000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.write_reg(a, d);
  endtask

  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    host_u.read_reg(a, v);
    chk(v, e);
  endtask

  task automatic pulse(input int idx);
    @(posedge core_clk);
    #1;
    amatch[idx] = 1'b1;
    @(posedge core_clk);
    #1;
    amatch = 2'h0;
  endtask

  // counts changes of the second pin enable over 40 core cycles
  task automatic toggles(output int n);
    logic p;
    n = 0;
    p = s_oe;
    repeat (40) begin
      @(posedge core_clk);
      #1;
      if (s_oe !== p) n++;
      p = s_oe;
    end
  endtask

  task automatic t_reset();
    int n;
    rchk(ADDR_CTRL2, 8'h10);
    rchk(ADDR_HOUR, 8'h12);
    wr(ADDR_CTRL1, 8'hFF);
    rchk(ADDR_CTRL1, 8'h00);
    chk(f_oe, 8'h00);
    wr(4'h8, 8'hFF);
    rchk(4'h8, 8'h00);
    toggles(n);
    chk(n > 0, 8'h01);
    wr(ADDR_CTRL2, 8'h08);
    rchk(ADDR_CTRL2, 8'h08);
  endtask

  task automatic t_clkout();
    int n;
    wr(ADDR_CTRL2, 8'h00);
    toggles(n);
    chk(n > 0, 8'h01);
    wr(ADDR_CTRL2, 8'h08);
    toggles(n);
    chk(n, 8'h00);
  endtask

  // st = {hour, day, month, year}, ex = {hour, day, month}, fl = {day, year}
  task automatic t_roll(input logic h24, input logic [31:0] st,
                        input logic [23:0] ex, input logic [1:0] fl);
    logic [7:0] v;
    year = st[7:0];
    ycarry_seen = 1'b0;
    wr(ADDR_CTRL2, {2'h0, h24, 5'h0F});
    wr(ADDR_HOUR, st[31:24]);
    wr(ADDR_DAY, st[23:16]);
    wr(ADDR_MON, st[15:8]);
    wr(ADDR_WDAY, 8'h06);
    wr(ADDR_MIN, 8'h59);
    wr(ADDR_SEC, 8'h59);
    v = 8'h59;
    for (int i = 0; i < 60 && v !== 8'h00; i++) host_u.read_reg(ADDR_SEC, v);
    chk(v, 8'h00);
    rchk(ADDR_MIN, 8'h00);
    rchk(ADDR_HOUR, ex[23:16]);
    rchk(ADDR_WDAY, fl[1] ? 8'h00 : 8'h06);
    rchk(ADDR_DAY, ex[15:8]);
    rchk(ADDR_MON, ex[7:0]);
    chk(ycarry_seen, fl[0]);
  endtask

  // enable field: bit 6 enables the first alarm, bit 7 the second
  task automatic t_alarm();
    wr(ADDR_CTRL1, 8'h40);
    pulse(0);
    chk(f_oe, 8'h01);
    chk({f_dat, s_dat}, 8'h00);
    rchk(ADDR_CTRL2, 8'h0A);
    wr(ADDR_CTRL2, 8'h2F);
    chk(f_oe, 8'h01);
    wr(ADDR_CTRL2, 8'h2D);
    chk(f_oe, 8'h00);
    pulse(0);
    wr(ADDR_CTRL1, 8'h00);
    rchk(ADDR_CTRL2, 8'h28);
    pulse(0);
    chk(f_oe, 8'h00);
    wr(ADDR_CTRL1, 8'h90);
    pulse(1);
    chk({f_oe, s_oe}, 8'h01);
    wr(ADDR_CTRL2, 8'h2E);
    chk(s_oe, 8'h00);
    wr(ADDR_CTRL1, 8'h00);
  endtask

  task automatic t_periodic();
    int i;
    wr(ADDR_CTRL1, 8'h04);
    for (i = 0; i < 60 && f_oe !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(f_oe, 8'h01);
    rchk(ADDR_CTRL2, 8'h2C);
    wr(ADDR_CTRL2, 8'h2F);
    chk(f_oe, 8'h01);
    wr(ADDR_CTRL2, 8'h2B);
    chk(f_oe, 8'h00);
    rchk(ADDR_CTRL2, 8'h28);
    // fixed-low mode: flag follows the pin, a write of 0 is ignored
    wr(ADDR_CTRL1, 8'h01);
    rchk(ADDR_CTRL2, 8'h2C);
    chk(f_oe, 8'h01);
    wr(ADDR_CTRL2, 8'h2B);
    chk(f_oe, 8'h01);
    wr(ADDR_CTRL1, 8'h00);
  endtask

  task automatic t_halt();
    int n;
    wr(ADDR_CTRL1, 8'h40);
    wr(ADDR_TRIM, 8'hFF);
    pulse(0);
    xtal_run = 1'b0;
    repeat (2200) @(posedge core_clk);
    xtal_run = 1'b1;
    rchk(ADDR_CTRL2, 8'h30);
    rchk(ADDR_CTRL1, 8'h00);
    rchk(ADDR_TRIM, 8'h00);
    chk(f_oe, 8'h00);
    toggles(n);
    chk(n > 0, 8'h01);
    wr(ADDR_CTRL2, 8'h20);
    rchk(ADDR_CTRL2, 8'h20);
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_clkout();
    t_roll(1'b1, 32'h2331_1223, 24'h00_0101, 2'h3);
    t_roll(1'b1, 32'h2328_0224, 24'h00_2902, 2'h2);
    t_roll(1'b1, 32'h2328_0223, 24'h00_0103, 2'h2);
    t_roll(1'b1, 32'h2330_0423, 24'h00_0105, 2'h2);
    t_roll(1'b1, 32'h2329_0200, 24'h00_0103, 2'h2);
    t_roll(1'b0, 32'h3115_0723, 24'h12_1607, 2'h2);
    t_roll(1'b0, 32'h1115_0723, 24'h32_1507, 2'h0);
    t_alarm();
    t_periodic();
    t_halt();
    tally_and_finish();
  end
endmodule

`default_nettype wire
